// ===== verilog/cva_consts.svh
// Constants for the card voltage class activation block
`ifndef CVA_CONSTS_SVH
`define CVA_CONSTS_SVH
`define CVA_OFS_CTRL     8'h00
`define CVA_OFS_STATUS   8'h04
`define CVA_OFS_IRQ_STAT 8'h08
`define CVA_OFS_IRQ_EN   8'h0C
`define CVA_OFS_IRQ_CLR  8'h10
`define CVA_OFS_CLASSES  8'h14
`define CVA_OFS_ATR_LEN  8'h18
`define CVA_OFS_ATR_BASE 8'h40
`define CVA_CLASS_RST    5'h02
`define CVA_ATR_LEN_RST  5'h0A
`define CVA_ATR_DEPTH    32
`define CVA_ETU_CLKS     9'h174
`define CVA_START_GAP    16'h0190
`define CVA_IRQ_COLD     0
`define CVA_IRQ_WARM     1
`define CVA_IRQ_DONE     2
`define CVA_IRQ_BAD      3
`endif

// ===== verilog/cva_pkg.sv
// Types for the card voltage class activation block
package cva_pkg;
    typedef enum logic [1:0] {
        CVA_IDLE = 2'b00,
        CVA_WAIT = 2'b01,
        CVA_SEND = 2'b10,
        CVA_DONE = 2'b11
    } cva_state_t;
endpackage

// ===== verilog/cva_char_tx.sv
// Character serialiser on the card clock for the answer bytes
`timescale 1ns/1ps
`default_nettype none
`include "cva_consts.svh"
module cva_char_tx (
    // System side
    input  wire logic       clk_sys,
    input  wire logic       rst,
    // Card clock rising edge seen in clk_sys domain
    input  wire logic       cardEdge,
    // Byte request
    input  wire logic       start,
    input  wire logic [7:0] data,
    output logic            busy,
    // Line drive, low when asserted
    output logic            lineLow
);
    logic [8:0] etuCnt_ff;
    logic [3:0] bitCnt_ff;
    logic [9:0] shift_ff;
    logic       busy_ff;

    // Start, eight data bits, even parity
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            busy_ff   <= 1'b0;
            etuCnt_ff <= 9'h000;
            bitCnt_ff <= 4'h0;
            shift_ff  <= 10'h3FF;
        end else if (!busy_ff && start) begin
            busy_ff   <= 1'b1;
            etuCnt_ff <= 9'h000;
            bitCnt_ff <= 4'h0;
            shift_ff  <= {^data, data, 1'b0};
        end else if (busy_ff && cardEdge) begin
            if (etuCnt_ff == `CVA_ETU_CLKS - 9'h001) begin
                etuCnt_ff <= 9'h000;
                shift_ff  <= {1'b1, shift_ff[9:1]};
                // Two extra bit times give the guard time
                if (bitCnt_ff == 4'hB) begin
                    busy_ff <= 1'b0;
                end
                bitCnt_ff <= bitCnt_ff + 4'h1;
            end else begin
                etuCnt_ff <= etuCnt_ff + 9'h001;
            end
        end
    end

    assign busy    = busy_ff;
    assign lineLow = busy_ff & ~shift_ff[0];
endmodule
`default_nettype wire

// ===== verilog/cva_card_atr.sv
// Card side answer-to-reset sequencer with voltage class reporting
//
// The address-and-strobe port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "cva_consts.svh"
module cva_card_atr (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // Card contacts, from the terminal
    input  wire logic        cardVccOn,
    input  wire logic        cardRstN,
    input  wire logic        cardClk,
    // Card I/O, open drain
    input  wire logic        ioIn,
    output logic             ioOut,
    output logic             ioOe,
    // Register port
    input  wire logic [7:0]  regAddr,
    input  wire logic [31:0] regWdata,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic [31:0]      regRdata,
    // Interrupt and status
    output logic             irq,
    output logic             coldReset
);
    // ********************************************
    // Pin synchronisers
    // ********************************************
    logic [1:0] vccSync_ff;
    logic [1:0] rstSync_ff;
    logic [1:0] clkSync_ff;
    logic [1:0] ioSync_ff;
    logic       clkPrev_ff;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            vccSync_ff <= 2'b00;
            rstSync_ff <= 2'b00;
            clkSync_ff <= 2'b00;
            ioSync_ff  <= 2'b11;
            clkPrev_ff <= 1'b0;
        end else begin
            vccSync_ff <= {vccSync_ff[0], cardVccOn};
            rstSync_ff <= {rstSync_ff[0], cardRstN};
            clkSync_ff <= {clkSync_ff[0], cardClk};
            ioSync_ff  <= {ioSync_ff[0], ioIn};
            clkPrev_ff <= clkSync_ff[1];
        end
    end
    logic vccOn;
    logic rstRel;
    logic cardEdge;
    assign vccOn    = vccSync_ff[1];
    assign rstRel   = rstSync_ff[1];
    assign cardEdge = clkSync_ff[1] & ~clkPrev_ff;

    // ********************************************
    // Registers
    // ********************************************
    logic [4:0] classes_ff;
    logic [4:0] atrLen_ff;
    logic [7:0] atrMem [0:`CVA_ATR_DEPTH-1];
    logic [3:0] irqEn_ff;
    logic [3:0] irqStat_ff;
    logic [3:0] irqSet;
    logic       enable_ff;
    logic       classBad;
    // Class mask must be one contiguous run of ones
    function automatic logic contig(input logic [4:0] m);
        logic [4:0] low;
        low    = m & (~m + 5'h01);
        contig = (m != 5'h00) && (((m + low) & m) == 5'h00);
    endfunction
    assign classBad = !contig(classes_ff);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            enable_ff  <= 1'b0;
            classes_ff <= `CVA_CLASS_RST;
            atrLen_ff  <= `CVA_ATR_LEN_RST;
            irqEn_ff   <= 4'h0;
        end else if (regWr) begin
            case (regAddr)
                `CVA_OFS_CTRL:    enable_ff  <= regWdata[0];
                `CVA_OFS_CLASSES: classes_ff <= regWdata[4:0];
                `CVA_OFS_ATR_LEN: atrLen_ff  <= regWdata[4:0];
                `CVA_OFS_IRQ_EN:  irqEn_ff   <= regWdata[3:0];
                default: ;
            endcase
        end
    end
    // Answer string memory, one byte per word from the window base
    // Software composes the T=15 class byte; the block only replays it
    logic [7:0] memOfs;
    assign memOfs = regAddr - `CVA_OFS_ATR_BASE;
    always_ff @(posedge clk_sys) begin
        if (regWr && memOfs < 8'h80) begin
            atrMem[memOfs[6:2]] <= regWdata[7:0];
        end
    end

    // ********************************************
    // Reset kind and answer sequencer
    // ********************************************
    cva_pkg::cva_state_t state_ff;
    logic [15:0] gap_ff;
    logic [4:0]  idx_ff;
    logic        seenReset_ff;
    logic        cold_ff;
    logic        rstPrev_ff;
    logic        seqRst;
    logic        txStart;
    logic        txBusy;
    logic        txLow;
    logic        txPend_ff;
    logic        rstRise;
    logic [7:0]  txByte;
    assign rstRise = rstRel & ~rstPrev_ff;
    // Contact loss or a held reset pin also stops a character mid-frame
    assign seqRst  = rst || !vccOn || !rstRel;
    assign txByte  = atrMem[idx_ff];
    assign txStart = (state_ff == cva_pkg::CVA_SEND) && !txBusy && !txPend_ff;

    // First reset after power-up of contacts is cold
    always_ff @(posedge clk_sys) begin
        if (rst || !vccOn) begin
            seenReset_ff <= 1'b0;
            cold_ff      <= 1'b0;
            rstPrev_ff   <= 1'b0;
        end else begin
            rstPrev_ff <= rstRel;
            if (rstRise) begin
                cold_ff      <= !seenReset_ff;
                seenReset_ff <= 1'b1;
            end
        end
    end

    // Answer goes out first; nothing else may use the line
    always_ff @(posedge clk_sys) begin
        if (seqRst) begin
            state_ff  <= cva_pkg::CVA_IDLE;
            gap_ff    <= 16'h0000;
            idx_ff    <= 5'h00;
            txPend_ff <= 1'b0;
        end else begin
            txPend_ff <= txStart;
            case (state_ff)
                cva_pkg::CVA_IDLE: begin
                    if (enable_ff && !classBad) begin
                        state_ff <= cva_pkg::CVA_WAIT;
                    end
                end
                cva_pkg::CVA_WAIT: begin
                    if (cardEdge) begin
                        gap_ff <= gap_ff + 16'h0001;
                    end
                    if (gap_ff == `CVA_START_GAP) begin
                        state_ff <= cva_pkg::CVA_SEND;
                    end
                end
                cva_pkg::CVA_SEND: begin
                    if (txPend_ff) begin
                        // Byte accepted by serialiser
                    end else if (!txBusy && !txStart) begin
                    end
                    if (txStart && idx_ff == atrLen_ff - 5'h01) begin
                        state_ff <= cva_pkg::CVA_DONE;
                    end else if (txStart) begin
                        idx_ff <= idx_ff + 5'h01;
                    end
                end
                cva_pkg::CVA_DONE: ;
                default: state_ff <= cva_pkg::CVA_IDLE;
            endcase
        end
    end

    cva_char_tx u_tx (
        .clk_sys (clk_sys),
        .rst     (seqRst),
        .cardEdge(cardEdge),
        .start   (txStart),
        .data    (txByte),
        .busy    (txBusy),
        .lineLow (txLow)
    );

    // ********************************************
    // Interrupts and outputs
    // ********************************************
    logic doneEdge_ff;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            doneEdge_ff <= 1'b0;
        end else begin
            doneEdge_ff <= (state_ff == cva_pkg::CVA_DONE) && !txBusy;
        end
    end
    assign irqSet[`CVA_IRQ_COLD] = rstRise && !seenReset_ff;
    assign irqSet[`CVA_IRQ_WARM] = rstRise && seenReset_ff;
    assign irqSet[`CVA_IRQ_DONE] = (state_ff == cva_pkg::CVA_DONE) && !txBusy
                                   && !doneEdge_ff;
    assign irqSet[`CVA_IRQ_BAD]  = classBad && enable_ff;
    // Set wins over a clear in the same cycle
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irqStat_ff <= 4'h0;
        end else begin
            irqStat_ff <= (irqStat_ff & ~((regWr && regAddr ==
                          `CVA_OFS_IRQ_CLR) ? regWdata[3:0] : 4'h0)) | irqSet;
        end
    end

    logic [31:0] rdata_ff;
    logic        irq_ff;
    logic        ioOe_ff;
    logic        cold_o_ff;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rdata_ff  <= 32'h00000000;
            irq_ff    <= 1'b0;
            ioOe_ff   <= 1'b0;
            cold_o_ff <= 1'b0;
        end else begin
            irq_ff    <= |(irqStat_ff & irqEn_ff);
            ioOe_ff   <= txLow;
            cold_o_ff <= cold_ff;
            rdata_ff  <= 32'h00000000;
            if (regRd) begin
                case (regAddr)
                    `CVA_OFS_CTRL:     rdata_ff <= {31'h0, enable_ff};
                    `CVA_OFS_STATUS:   rdata_ff <= {26'h0, ioSync_ff[1],
                        classBad, cold_ff, state_ff, vccOn};
                    `CVA_OFS_IRQ_STAT: rdata_ff <= {28'h0, irqStat_ff};
                    `CVA_OFS_IRQ_EN:   rdata_ff <= {28'h0, irqEn_ff};
                    `CVA_OFS_CLASSES:  rdata_ff <= {27'h0, classes_ff};
                    `CVA_OFS_ATR_LEN:  rdata_ff <= {27'h0, atrLen_ff};
                    default: ;
                endcase
            end
        end
    end
    assign regRdata  = rdata_ff;
    assign irq       = irq_ff;
    assign ioOe      = ioOe_ff;
    assign ioOut     = 1'b0;
    assign coldReset = cold_o_ff;

    // ********************************************
    // Checks
    // ********************************************
    no_early_tx_a: assert property (@(posedge clk_sys) disable iff (rst)
        txBusy |-> (state_ff == cva_pkg::CVA_SEND ||
        state_ff == cva_pkg::CVA_DONE))
        else $error("line driven outside answer");
    bad_mask_a: assert property (@(posedge clk_sys) disable iff (rst)
        classBad |-> state_ff != cva_pkg::CVA_WAIT || $past(state_ff) ==
        cva_pkg::CVA_WAIT)
        else $error("answer started with gapped class mask");
    cold_first_a: assert property (@(posedge clk_sys) disable iff (rst)
        (rstRise && !seenReset_ff && vccOn) |=> cold_ff)
        else $error("first reset not cold");
    warm_later_a: assert property (@(posedge clk_sys) disable iff (rst)
        (rstRise && seenReset_ff && vccOn) |=> !cold_ff)
        else $error("later reset not warm");
    irq_level_a: assert property (@(posedge clk_sys) disable iff (rst)
        |(irqStat_ff & irqEn_ff) |=> irq)
        else $error("interrupt not raised");
    set_wins_a: assert property (@(posedge clk_sys) disable iff (rst)
        irqSet[`CVA_IRQ_COLD] |=> irqStat_ff[`CVA_IRQ_COLD])
        else $error("event lost");
    oe_follows_a: assert property (@(posedge clk_sys) disable iff (rst)
        txLow |=> ioOe)
        else $error("line drive lost");
    mask_read_a: assert property (@(posedge clk_sys) disable iff (rst)
        (regRd && regAddr == `CVA_OFS_CLASSES) |=> regRdata[4:0] ==
        $past(classes_ff))
        else $error("class mask readback wrong");
    cold_c: cover property (@(posedge clk_sys) irqSet[`CVA_IRQ_COLD]);
    warm_c: cover property (@(posedge clk_sys) irqSet[`CVA_IRQ_WARM]);
    done_c: cover property (@(posedge clk_sys) irqSet[`CVA_IRQ_DONE]);
endmodule
`default_nettype wire

// ===== dv/cva_term_model.sv
// Terminal model: card supply, clock, reset and answer receiver
`timescale 1ns/1ps
`default_nettype none
module cva_term_model (
    // Card contacts
    output logic      cardVccOn,
    output logic      cardRstN,
    output logic      cardClk,
    // Pulled-up I/O wire
    input  wire logic ioLine
);
    logic clkRun   = 1'b0;
    int   classTry = 0;
    int   badRuns  = 0;
    // Contacts start off
    initial begin
        cardVccOn = 1'b0;
        cardRstN  = 1'b0;
        cardClk   = 1'b0;
    end
    // Clock stands low while off; 3 ns offset keeps it off the system edge
    initial begin
        #3;
        forever begin
            #40;
            cardClk = clkRun ? ~cardClk : 1'b0;
        end
    end
    task automatic ticks(input int n);
        repeat (n) @(posedge cardClk);
    endtask
    // Supply at the lowest class first, reset released only after it
    task automatic activate();
        classTry  = 0;
        badRuns   = 0;
        cardVccOn = 1'b1;
        clkRun    = 1'b1;
        ticks(50);
        cardRstN  = 1'b1;
    endtask
    // Reset first so the card never sees a live reset without supply
    task automatic deactivate();
        cardRstN  = 1'b0;
        ticks(5);
        clkRun    = 1'b0;
        cardVccOn = 1'b0;
    endtask
    // Class walk after an answer: bad ones retried, unsupported moved
    task automatic afterAnswer(input logic good, input logic [7:0] mask);
        if (!good) begin
            badRuns++;
            if (badRuns == 3) begin
                // Only the very next class, never one further up
                badRuns = 0;
                classTry++;
            end
        end else if (!mask[classTry]) begin
            badRuns  = 0;
            classTry = 0;
            while (classTry < 4 && !mask[classTry]) begin
                classTry++;
            end
        end
    endtask
    task automatic warmReset();
        cardRstN = 1'b0;
        ticks(50);
        cardRstN = 1'b1;
    endtask
    // One character; a silent card for 1000 clocks steps the class up
    task automatic rxByte(output logic [7:0] b, output int gap,
                          output logic ok);
        logic [8:0] bits;
        gap = 0;
        ok  = 1'b0;
        b   = 8'h00;
        while (ioLine === 1'b1 && gap < 1000) begin
            ticks(1);
            gap++;
        end
        if (gap >= 1000) begin
            classTry++;
        end else begin
            ticks(186);
            for (int i = 0; i < 9; i++) begin
                ticks(372);
                bits[i] = ioLine;
            end
            ticks(372);
            b  = bits[7:0];
            ok = (^bits === 1'b0) && (ioLine === 1'b1);
        end
    endtask
endmodule
`default_nettype wire

// ===== dv/card_voltage_class_activation_tb.sv
// Self-checking bench for the card answer-to-reset block
`timescale 1ns/1ps
`default_nettype none
`include "cva_consts.svh"
module card_voltage_class_activation_tb;
    logic        clk_sys;
    logic        rst;
    logic [7:0]  regAddr;
    logic [31:0] regWdata;
    logic        regWr;
    logic        regRd;
    logic [31:0] regRdata;
    logic        ioOut, ioOe, irq, coldReset, ok;
    logic [7:0]  atrByte;
    wire logic   cardVccOn, cardRstN, cardClk, ioIn;
    int          err_total    = 0;
    int          total_checks = 0;
    int          gap;
    // Only the card pulls the wire; the pull-up wins otherwise
    assign ioIn = ~ioOe;
    initial clk_sys = 1'b0;
    always #5 clk_sys = ~clk_sys;
    cva_card_atr dut_u (
        .clk_sys(clk_sys), .rst(rst), .cardVccOn(cardVccOn),
        .cardRstN(cardRstN), .cardClk(cardClk), .ioIn(ioIn),
        .ioOut(ioOut), .ioOe(ioOe), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .irq(irq), .coldReset(coldReset)
    );
    cva_term_model term_u (
        .cardVccOn(cardVccOn), .cardRstN(cardRstN),
        .cardClk(cardClk), .ioLine(ioIn)
    );
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Each access starts on a rising edge; strobe lowered at the next one
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        regAddr  <= a;
        regWdata <= d;
        regWr    <= 1'b1;
        @(posedge clk_sys);
        regWr    <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe edge
    task automatic rdChk(input logic [7:0] a, input logic [31:0] m,
                         input logic [31:0] e);
        @(posedge clk_sys);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge clk_sys);
        regRd   <= 1'b0;
        #1;
        chk(regRdata & m, e);
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Watchdog sized well above the longest answer frame
    initial begin
        repeat (90000) @(posedge clk_sys);
        err_total++;
        stop_test();
    end
    initial begin
        rst      <= 1'b1;
        regAddr  <= 8'h00;
        regWdata <= 32'h0;
        regWr    <= 1'b0;
        regRd    <= 1'b0;
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        // Reset values, unmapped hole, quiet outputs
        rdChk(`CVA_OFS_CLASSES, 32'hFF, {27'h0, `CVA_CLASS_RST});
        rdChk(`CVA_OFS_ATR_LEN, 32'hFF, {27'h0, `CVA_ATR_LEN_RST});
        rdChk(8'h3C, 32'hFFFFFFFF, 32'h0);
        rdChk(`CVA_OFS_IRQ_STAT, 32'hF, 32'h0);
        chk({28'h0, ioOut, ioOe, irq, coldReset}, 32'h0);
        $display("test reset values done");
        // Gapped mask A and C: flagged, card stays silent
        wr(`CVA_OFS_IRQ_EN, 32'hF);
        wr(`CVA_OFS_CTRL, 32'h1);
        wr(`CVA_OFS_CLASSES, 32'h5);
        rdChk(`CVA_OFS_STATUS, 32'h10, 32'h10);
        term_u.activate();
        term_u.rxByte(atrByte, gap, ok);
        chk({31'h0, ok}, 32'h0);
        chk(term_u.classTry, 32'h1);
        rdChk(`CVA_OFS_IRQ_STAT, 32'h8, 32'h8);
        term_u.deactivate();
        // Mend the mask first, else the sticky flag sets again at once
        wr(`CVA_OFS_CLASSES, 32'h3);
        wr(`CVA_OFS_IRQ_CLR, 32'hF);
        $display("test gapped mask done");
        // Cold activation, interrupt clear and mask, one answer byte
        wr(`CVA_OFS_CLASSES, 32'h3);
        rdChk(`CVA_OFS_STATUS, 32'h10, 32'h0);
        wr(`CVA_OFS_ATR_LEN, 32'h1);
        wr(`CVA_OFS_ATR_BASE, 32'h3); // T=15 byte, classes A and B
        term_u.activate();
        term_u.ticks(4);
        chk({31'h0, coldReset}, 32'h1);
        chk({31'h0, irq}, 32'h1);
        rdChk(`CVA_OFS_IRQ_STAT, 32'h3, 32'h1);
        wr(`CVA_OFS_IRQ_CLR, 32'h1);
        term_u.ticks(1);
        rdChk(`CVA_OFS_IRQ_STAT, 32'h1, 32'h0);
        chk({31'h0, irq}, 32'h0);
        term_u.rxByte(atrByte, gap, ok);
        chk({31'h0, ok}, 32'h1);
        chk({24'h0, atrByte}, 32'h03);
        term_u.afterAnswer(ok, atrByte);
        chk(term_u.classTry, 32'h0);
        chk({31'h0, gap >= 385 && gap <= 405}, 32'h1);
        // One and a half guard bits still run after the receiver returns
        term_u.ticks(600);
        rdChk(`CVA_OFS_IRQ_STAT, 32'h4, 32'h4);
        wr(`CVA_OFS_IRQ_EN, 32'h1);
        term_u.ticks(1);
        chk({31'h0, irq}, 32'h0);
        wr(`CVA_OFS_IRQ_EN, 32'hF);
        term_u.ticks(1);
        chk({31'h0, irq}, 32'h1);
        wr(`CVA_OFS_IRQ_CLR, 32'hF);
        $display("test cold answer done");
        // Reset while powered is warm; power cycle makes it cold again
        wr(`CVA_OFS_CTRL, 32'h0);
        term_u.warmReset();
        term_u.ticks(4);
        chk({31'h0, coldReset}, 32'h0);
        rdChk(`CVA_OFS_IRQ_STAT, 32'h3, 32'h2);
        term_u.deactivate();
        wr(`CVA_OFS_IRQ_CLR, 32'hF);
        term_u.activate();
        term_u.ticks(4);
        chk({31'h0, coldReset}, 32'h1);
        rdChk(`CVA_OFS_IRQ_STAT, 32'h3, 32'h1);
        $display("test warm and cold done");
        // Terminal class walk on corrupted and unsupported answers
        repeat (2) term_u.afterAnswer(1'b0, 8'h00);
        chk(term_u.classTry, 32'h0);
        term_u.afterAnswer(1'b0, 8'h00);
        chk(term_u.classTry, 32'h1);
        term_u.afterAnswer(1'b1, 8'h04);
        chk(term_u.classTry, 32'h2);
        $display("test class walk done");
        stop_test();
    end
endmodule
`default_nettype wire
